// File: sstap_top.v
// tap controller and boundary-run test operations of the scan transceiver
`timescale 1ns/1ps
`include "sstap_map.vh"
module sstap_top #(
   parameter [35:0] TAPS36 = `SSTAP_TAPS36,
   parameter [17:0] TAPS18 = `SSTAP_TAPS18
) (
   // clock, reset, enable
   input wire core_clk_in,
   input wire rst_n_in,
   input wire ce_in,
   // test access port pins
   input wire tck_in,
   input wire tms_in,
   input wire tdi_in,
   output reg tdo_out,
   output reg tdo_oe_out,
   // a-side pins
   input wire [17:0] a_pin_in,
   output reg [17:0] a_pin_out,
   output reg [17:0] a_pin_oe_out,
   // b-side pins
   input wire [17:0] b_pin_in,
   output reg [17:0] b_pin_out,
   output reg [17:0] b_pin_oe_out
);
   localparam [3:0] ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
      ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PAU_DR = 4'h6, ST_EX2_DR = 4'h7, ST_UPD_DR = 4'h8,
      ST_SEL_IR = 4'h9, ST_CAP_IR = 4'hA, ST_SH_IR = 4'hB, ST_EX1_IR = 4'hC, ST_PAU_IR = 4'hD,
      ST_EX2_IR = 4'hE, ST_UPD_IR = 4'hF;

   // pin synchronisers: first stage read only by the second
   reg tck_s1_ff, tck_s2_ff, tck_s3_ff, tms_s1_ff, tms_s2_ff, tdi_s1_ff, tdi_s2_ff;
   reg [17:0] a_s1_ff, a_s2_ff, b_s1_ff, b_s2_ff;
   reg [3:0] state_ff;
   reg [3:0] nxt_state;
   reg [7:0] ir_shift_ff, ir_ff;
   reg [2:0] tcr_ff;
   reg bypass_ff;
   reg [39:0] chain_ff;
   reg [17:0] a_shadow_ff, b_shadow_ff;
   reg [3:0] oe_shadow_ff;
   reg test_mode_ff;
   reg [39:0] nxt_chain;
   reg [17:0] in_cells, out_cells, in_pins;
   reg [17:0] nxt_a_shadow, nxt_b_shadow;

   wire tck_rise = tck_s2_ff & ~tck_s3_ff;
   wire tck_fall = ~tck_s2_ff & tck_s3_ff;
   wire is_chain = (ir_ff == `SSTAP_OP_CHAIN);
   wire is_tcr = (ir_ff == `SSTAP_OP_TCR);
   wire is_run = (ir_ff == `SSTAP_OP_RUN);
   wire dir_ab = oe_shadow_ff[3];
   wire dir_ok = (oe_shadow_ff[3] == oe_shadow_ff[1]) && (oe_shadow_ff[2] == oe_shadow_ff[0]) &&
      (oe_shadow_ff[3] == oe_shadow_ff[2]);
   wire run_active = is_run && dir_ok && (state_ff == ST_IDLE);
   wire in_shift = (state_ff == ST_SH_DR) || (state_ff == ST_SH_IR);

   wire [35:0] sig36_next;
   wire [17:0] sig18_next, rnd18_next;

   sstap_lfsr #(.WIDTH(36), .TAPS(TAPS36)) u_sig36 (
      .state_in(chain_ff[35:0]),
      .data_in({18'h00000, in_pins}),
      .next_out(sig36_next)
   );
   sstap_lfsr #(.WIDTH(18), .TAPS(TAPS18)) u_sig18 (
      .state_in(in_cells),
      .data_in(in_pins),
      .next_out(sig18_next)
   );
   sstap_lfsr #(.WIDTH(18), .TAPS(TAPS18)) u_rnd18 (
      .state_in(out_cells),
      .data_in(18'h00000),
      .next_out(rnd18_next)
   );

   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_RESET: nxt_state = tms_s2_ff ? ST_RESET : ST_IDLE;
         ST_IDLE: nxt_state = tms_s2_ff ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: nxt_state = tms_s2_ff ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: nxt_state = tms_s2_ff ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR: nxt_state = tms_s2_ff ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: nxt_state = tms_s2_ff ? ST_UPD_DR : ST_PAU_DR;
         ST_PAU_DR: nxt_state = tms_s2_ff ? ST_EX2_DR : ST_PAU_DR;
         ST_EX2_DR: nxt_state = tms_s2_ff ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: nxt_state = tms_s2_ff ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: nxt_state = tms_s2_ff ? ST_RESET : ST_CAP_IR;
         ST_CAP_IR: nxt_state = tms_s2_ff ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR: nxt_state = tms_s2_ff ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: nxt_state = tms_s2_ff ? ST_UPD_IR : ST_PAU_IR;
         ST_PAU_IR: nxt_state = tms_s2_ff ? ST_EX2_IR : ST_PAU_IR;
         ST_EX2_IR: nxt_state = tms_s2_ff ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: nxt_state = tms_s2_ff ? ST_SEL_DR : ST_IDLE;
         default: nxt_state = ST_RESET;
      endcase
   end

   // input group and output group by direction
   always @* begin
      in_cells = dir_ab ? chain_ff[35:18] : chain_ff[17:0];
      out_cells = dir_ab ? chain_ff[17:0] : chain_ff[35:18];
      in_pins = dir_ab ? a_s2_ff : b_s2_ff;
   end

   // 36-bit signature modes keep shadows
   // shadow values taken on the next test-clock fall
   always @* begin
      nxt_a_shadow = a_shadow_ff;
      nxt_b_shadow = b_shadow_ff;
      if (state_ff == ST_UPD_DR && is_chain) begin
         nxt_a_shadow = chain_ff[35:18];
         nxt_b_shadow = chain_ff[17:0];
      end else if (run_active && tcr_ff[1:0] != `SSTAP_MODE_PSA36) begin
         if (dir_ab) begin
            nxt_b_shadow = chain_ff[17:0];
         end else begin
            nxt_a_shadow = chain_ff[35:18];
         end
      end
   end

   // boundary chain next value on a test-clock rise
   always @* begin
      nxt_chain = chain_ff;
      if (state_ff == ST_CAP_DR && is_chain) begin
         nxt_chain[35:18] = a_s2_ff;
         nxt_chain[17:0] = b_s2_ff;
      end else if (state_ff == ST_SH_DR && is_chain) begin
         nxt_chain = {tdi_s2_ff, chain_ff[39:1]};
      end else if (run_active) begin
         case (tcr_ff)
            3'h2, 3'h6: begin
               nxt_chain[35:0] = sig36_next;
            end
            3'h1, 3'h5: begin
               nxt_chain[35:0] = {chain_ff[34:0], ^(chain_ff[35:0] & TAPS36)};
            end
            3'h3: begin
               if (dir_ab) begin
                  nxt_chain[35:0] = {sig18_next, rnd18_next};
               end else begin
                  nxt_chain[35:0] = {rnd18_next, sig18_next};
               end
            end
            3'h7: begin
               if (dir_ab) begin
                  nxt_chain[35:0] = {sig18_next, out_cells + 18'h00001};
               end else begin
                  nxt_chain[35:0] = {out_cells + 18'h00001, sig18_next};
               end
            end
            default: begin
               if (dir_ab) begin
                  nxt_chain[35:0] = {a_s2_ff, ~out_cells};
               end else begin
                  nxt_chain[35:0] = {~out_cells, b_s2_ff};
               end
            end
         endcase
      end
   end

   // synchronisers on every enabled core clock, everything else on the sampled test clock
   always @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         tck_s1_ff <= 1'b0;
         tck_s2_ff <= 1'b0;
         tck_s3_ff <= 1'b0;
         tms_s1_ff <= 1'b1;
         tms_s2_ff <= 1'b1;
         tdi_s1_ff <= 1'b0;
         tdi_s2_ff <= 1'b0;
         a_s1_ff <= 18'h00000;
         a_s2_ff <= 18'h00000;
         b_s1_ff <= 18'h00000;
         b_s2_ff <= 18'h00000;
         state_ff <= ST_RESET;
         ir_shift_ff <= `SSTAP_IR_CAPTURE;
         ir_ff <= `SSTAP_OP_BYPASS;
         tcr_ff <= `SSTAP_TCR_RESET;
         bypass_ff <= 1'b0;
         chain_ff <= 40'h0000000000;
         a_shadow_ff <= 18'h00000;
         b_shadow_ff <= 18'h00000;
         oe_shadow_ff <= 4'h0;
         test_mode_ff <= 1'b0;
         tdo_out <= 1'b0;
         tdo_oe_out <= 1'b0;
         a_pin_out <= 18'h00000;
         a_pin_oe_out <= 18'h00000;
         b_pin_out <= 18'h00000;
         b_pin_oe_out <= 18'h00000;
      end else if (ce_in) begin
         tck_s1_ff <= tck_in;
         tck_s2_ff <= tck_s1_ff;
         tck_s3_ff <= tck_s2_ff;
         tms_s1_ff <= tms_in;
         tms_s2_ff <= tms_s1_ff;
         tdi_s1_ff <= tdi_in;
         tdi_s2_ff <= tdi_s1_ff;
         a_s1_ff <= a_pin_in;
         a_s2_ff <= a_s1_ff;
         b_s1_ff <= b_pin_in;
         b_s2_ff <= b_s1_ff;
         if (tck_rise) begin
            state_ff <= nxt_state;
            chain_ff <= nxt_chain;
            if (state_ff == ST_CAP_IR) begin
               ir_shift_ff <= `SSTAP_IR_CAPTURE;
            end else if (state_ff == ST_SH_IR) begin
               // shift in at msb, out at lsb
               ir_shift_ff <= {tdi_s2_ff, ir_shift_ff[7:1]};
            end
            if (state_ff == ST_CAP_DR) begin
               bypass_ff <= 1'b0;
            end else if (state_ff == ST_SH_DR) begin
               bypass_ff <= tdi_s2_ff;
               if (is_tcr) begin
                  tcr_ff <= {tdi_s2_ff, tcr_ff[2:1]};
               end
            end
         end
         // outputs change on falling test clock
         if (tck_fall) begin
            // driver on while in a shift state
            tdo_oe_out <= in_shift;
            if (state_ff == ST_SH_IR) begin
               tdo_out <= ir_shift_ff[0];
            end else if (state_ff == ST_SH_DR) begin
               tdo_out <= is_chain ? chain_ff[0] : (is_tcr ? tcr_ff[0] : bypass_ff);
            end
            if (state_ff == ST_RESET) begin
               ir_ff <= `SSTAP_OP_BYPASS;
               test_mode_ff <= 1'b0;
            end else if (state_ff == ST_UPD_IR) begin
               ir_ff <= ir_shift_ff;
               test_mode_ff <= (ir_shift_ff == `SSTAP_OP_CHAIN) || (ir_shift_ff == `SSTAP_OP_RUN);
            end
            if (state_ff == ST_UPD_DR && is_chain) begin
               oe_shadow_ff <= chain_ff[39:36];
            end
            // pins show new shadow this fall
            a_shadow_ff <= nxt_a_shadow;
            b_shadow_ff <= nxt_b_shadow;
            a_pin_out <= nxt_a_shadow;
            b_pin_out <= nxt_b_shadow;
            // b drives with ab enable, a drives with ba enable low
            b_pin_oe_out <= test_mode_ff ? {{9{oe_shadow_ff[2]}}, {9{oe_shadow_ff[3]}}} : 18'h00000;
            a_pin_oe_out <= test_mode_ff ? {{9{~oe_shadow_ff[0]}}, {9{~oe_shadow_ff[1]}}} : 18'h00000;
         end
      end
   end
endmodule

// File: sstap_map.vh
// constants for the scan signature test-operation block
`ifndef SSTAP_MAP_VH
`define SSTAP_MAP_VH
`define SSTAP_IR_W 8
`define SSTAP_IR_CAPTURE 8'h81
`define SSTAP_OP_BYPASS 8'hFF
`define SSTAP_OP_CHAIN 8'h82
`define SSTAP_OP_TCR 8'h8E
`define SSTAP_OP_RUN 8'h09
`define SSTAP_TCR_W 3
`define SSTAP_TCR_RESET 3'h0
`define SSTAP_MODE_PSA36 2'h2
`define SSTAP_MODE_RANDOM 3'h3
`define SSTAP_MODE_COUNT 3'h7
`define SSTAP_MODE_TOGGLE 2'h0
`define SSTAP_MODE_PRPG36 2'h1
`define SSTAP_HALF 18
`define SSTAP_CHAIN_W 40
`define SSTAP_OE1_AB 39
`define SSTAP_OE2_AB 38
`define SSTAP_OE1_BA 37
`define SSTAP_OE2_BA 36
`define SSTAP_TAPS36 36'h800000801
`define SSTAP_TAPS18 18'h20041
`endif

// File: sstap_lfsr.v
// one step of a shift-register signature or pattern generator
`timescale 1ns/1ps
module sstap_lfsr #(
   parameter WIDTH = 18,
   parameter [WIDTH-1:0] TAPS = {WIDTH{1'b0}}
) (
   // present value and parallel data folded in
   input wire [WIDTH-1:0] state_in,
   input wire [WIDTH-1:0] data_in,
   // next value
   output wire [WIDTH-1:0] next_out
);
   // zero state with zero data stays zero
   assign next_out = {state_in[WIDTH-2:0], ^(state_in & TAPS)} ^ data_in;
endmodule

// File: sstap_top_monitor.sv
// checker for tap and pin output timing of the scan test-operation block
`timescale 1ns/1ps
module sstap_top_monitor (
   // clock and reset
   input wire core_clk_in,
   input wire rst_n_in,
   // tap
   input wire tck_in,
   input wire tdo_out,
   input wire tdo_oe_out,
   // pins
   input wire [17:0] a_pin_out,
   input wire [17:0] a_pin_oe_out,
   input wire [17:0] b_pin_out,
   input wire [17:0] b_pin_oe_out
);
   reg tck_d_ff;
   reg [3:0] still_ff;
   // counts core cycles since the last tck edge
   always @(posedge core_clk_in) begin
      tck_d_ff <= tck_in;
      if (!rst_n_in || tck_in != tck_d_ff)
         still_ff <= 4'h0;
      else if (still_ff != 4'hF)
         still_ff <= still_ff + 4'h1;
   end
   default clocking mon_cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   property p_tdo_fall;
      $changed(tdo_out) |-> !$past(tck_in, 2);
   endproperty
   a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved outside tck low");
   property p_oe_fall;
      $changed(tdo_oe_out) |-> !$past(tck_in, 2);
   endproperty
   a_oe_fall: assert property (p_oe_fall) else $error("tdo enable moved outside tck low");
   property p_a_fall;
      $changed(a_pin_out) || $changed(a_pin_oe_out) |-> !$past(tck_in, 2);
   endproperty
   a_a_fall: assert property (p_a_fall) else $error("a pins moved outside tck low");
   property p_b_fall;
      $changed(b_pin_out) || $changed(b_pin_oe_out) |-> !$past(tck_in, 2);
   endproperty
   a_b_fall: assert property (p_b_fall) else $error("b pins moved outside tck low");
   property p_reset_quiet;
      $rose(rst_n_in) |-> !tdo_oe_out && a_pin_oe_out == 18'h0 && b_pin_oe_out == 18'h0 && b_pin_out == 18'h0;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet after reset");
   property p_byte_dir;
      (a_pin_oe_out[8:0] == 9'h0 || &a_pin_oe_out[8:0]) && (b_pin_oe_out[17:9] == 9'h0 || &b_pin_oe_out[17:9]);
   endproperty
   a_byte_dir: assert property (p_byte_dir) else $error("byte drive enables split");
   property p_still;
      still_ff >= 4'h6 |-> $stable(tdo_out) && $stable(tdo_oe_out) && $stable(a_pin_out) && $stable(b_pin_out);
   endproperty
   a_still: assert property (p_still) else $error("outputs moved without tck edge");
   property p_oe_hold;
      $rose(tdo_oe_out) |=> tdo_oe_out [*6];
   endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("tdo enable too short");
endmodule
bind sstap_top sstap_top_monitor mon (.core_clk_in, .rst_n_in, .tck_in, .tdo_out, .tdo_oe_out,
   .a_pin_out, .a_pin_oe_out, .b_pin_out, .b_pin_oe_out);

// File: sstap_ctl_model.sv
// test controller model driving the tap pins
`timescale 1ns/1ps
module sstap_ctl_model (
   // clock
   input wire clk_in,
   // tap pins
   input wire tdo_in,
   output reg tck_out,
   output reg tms_out,
   output reg tdi_out
);
   initial begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b0;
   end
   task step(input logic m, input logic d, output logic o);
      begin
         tms_out <= m;
         tdi_out <= d;
         repeat (4) @(posedge clk_in);
         tck_out <= 1'b1;
         repeat (4) @(posedge clk_in);
         o = tdo_in;
         tck_out <= 1'b0;
      end
   endtask
   task mv(input logic m);
      logic o;
      begin
         step(m, ~tdi_out, o);
      end
   endtask
   task go_idle;
      begin
         repeat (5) mv(1'b1);
         mv(1'b0);
         repeat (10) @(posedge clk_in);
      end
   endtask
   // walk through capture to shift; tms high on last bit
   task scan(input logic ir, input logic [39:0] din, input int n, output logic [39:0] dout);
      logic o;
      begin
         dout = 40'h0;
         mv(1'b1);
         if (ir)
            mv(1'b1);
         mv(1'b0);
         mv(1'b0);
         for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
         end
         mv(1'b1);
         mv(1'b0);
         repeat (10) @(posedge clk_in);
      end
   endtask
endmodule

// File: testbench.sv
// self-checking bench for the scan test-operation block
`timescale 1ns/1ps
`include "sstap_map.vh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
   reg core_clk_in = 1'b0;
   reg rst_n_in = 1'b0;
   reg ce_in = 1'b1;
   reg [17:0] a_pin_in = 18'h0;
   reg [17:0] b_pin_in = 18'h0;
   wire tck, tms, tdi, tdo, tdo_oe;
   wire [17:0] a_out, a_oe, b_out, b_oe;
   integer mismatches = 0;
   integer compares = 0;
   logic [39:0] q;
   sstap_top uut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .tck_in(tck), .tms_in(tms),
      .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe), .a_pin_in(a_pin_in), .a_pin_out(a_out),
      .a_pin_oe_out(a_oe), .b_pin_in(b_pin_in), .b_pin_out(b_out), .b_pin_oe_out(b_oe));
   sstap_ctl_model ctl (.clk_in(core_clk_in), .tdo_in(tdo), .tck_out(tck), .tms_out(tms), .tdi_out(tdi));
   initial forever #5 core_clk_in = ~core_clk_in;
   task results;
      begin
         $display("compares=%0d mismatches=%0d", compares, mismatches);
         if (mismatches == 0 && compares > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   // seed, control and run op scanned in first
   task run(input logic [39:0] ch, input logic [2:0] mode);
      begin
         ctl.scan(1'b1, {32'h0, `SSTAP_OP_CHAIN}, 8, q);
         ctl.scan(1'b0, ch, 40, q);
         ctl.scan(1'b1, {32'h0, `SSTAP_OP_TCR}, 8, q);
         ctl.scan(1'b0, {37'h0, mode}, 3, q);
         ctl.scan(1'b1, {32'h0, `SSTAP_OP_RUN}, 8, q);
         ctl.mv(1'b0);
         `CHK(b_out, ch[17:0])
      end
   endtask
   task t_ir;
      begin
         ctl.scan(1'b1, 40'hFF, 8, q);
         `CHK(q[7:0], `SSTAP_IR_CAPTURE)
         `CHK(tdo_oe, 1'b0)
         ctl.scan(1'b0, 40'h5, 3, q);
         `CHK(q[2:0], 3'h2)
         $display("t_ir done");
      end
   endtask
   task t_chain;
      begin
         a_pin_in <= 18'h2C0F1;
         b_pin_in <= 18'h01234;
         ctl.scan(1'b1, {32'h0, `SSTAP_OP_CHAIN}, 8, q);
         ctl.scan(1'b0, 40'h3000000000, 40, q);
         ctl.scan(1'b0, 40'h3000000000, 40, q);
         `CHK(q, {4'h3, 18'h2C0F1, 18'h01234})
         $display("t_chain done");
      end
   endtask
   task t_count;
      begin
         run({4'hF, 18'h0, 18'h00005}, 3'h7);
         a_pin_in <= 18'h15555;
         repeat (5) ctl.mv(1'b0);
         `CHK(b_out, 18'h0000A)
         `CHK(b_oe, 18'h3FFFF)
         `CHK(a_oe, 18'h0)
         // frozen across two test clocks: the count must not move
         repeat (8) @(posedge core_clk_in);
         ce_in <= 1'b0;
         repeat (2) ctl.mv(1'b0);
         ce_in <= 1'b1;
         ctl.mv(1'b0);
         `CHK(b_out, 18'h0000B)
         $display("t_count done");
      end
   endtask
   task t_random;
      begin
         run({4'hF, 36'h0}, 3'h3);
         repeat (4) ctl.mv(1'b0);
         `CHK(b_out, 18'h0)
         run({4'hF, 18'h0, 18'h00001}, 3'h3);
         ctl.mv(1'b0);
         `CHK(b_out, {16'h0000, 1'h1, ^(18'h00001 & `SSTAP_TAPS18)})
         $display("t_random done");
      end
   endtask
   task t_hold(input logic [3:0] oe, input logic [2:0] mode);
      begin
         run({oe, 18'h0, 18'h00033}, mode);
         a_pin_in <= 18'h0F0F0;
         repeat (3) ctl.mv(1'b0);
         `CHK(b_out, 18'h00033)
         $display("t_hold done");
      end
   endtask
   initial begin
      repeat (10) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      @(posedge core_clk_in);
      ctl.go_idle();
      t_ir();
      t_chain();
      t_count();
      t_random();
      t_hold(4'hF, 3'h2);
      t_hold(4'hC, 3'h7);
      results();
   end
   initial begin
      #900000;
      mismatches++;
      results();
   end
endmodule
